/* sbr_pkg.sv */
// Purpose: Shared constants and carriers for the single-read system bus master.
// Assumes: One 200 MHz core clock; the bus controller sits on the same clock.
// Notes:   Only the read path is active; the write data bus stays idle.
`default_nettype none

package sbr_pkg;

  // Bus geometry
  localparam int ADDR_HI = 35;
  localparam int ADDR_LO = 3;
  localparam int DATA_W  = 64;
  localparam int BE_W    = 8;

  // Outstanding transaction limit
  localparam int          CNT_W           = 5;
  localparam logic [4:0]  MAX_OUTSTANDING = 5'h10;
  localparam logic [4:0]  CNT_ONE         = 5'h01;
  localparam logic [4:0]  CNT_RESET       = 5'h00;

  // Request buffer
  localparam int          BUF_DEPTH       = 2;
  localparam logic [1:0]  BUF_FULL_CNT    = 2'h2;
  localparam logic [1:0]  BUF_RESET_CNT   = 2'h0;

  // Direction encoding on the bus
  localparam logic        DIR_READ        = 1'b0;

  typedef struct packed {
    logic [ADDR_HI:ADDR_LO] addr;
    logic [BE_W-1:0]        be;
    logic                   ifetch;
    logic                   uncached;
  } sbr_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              err;
  } sbr_rsp_t;

  typedef enum logic [2:0] {
    SBR_IDLE  = 3'b001,
    SBR_OFFER = 3'b010,
    SBR_HOLD  = 3'b100
  } sbr_state_t;

endpackage

`default_nettype wire

/* sbr_req_buf.sv */
// Purpose: Two-entry request buffer between the core and the address stage.
// Assumes: Same clock on both sides; synchronous active-high reset.
// Notes:   Absorbs a stalled address phase so no request word is dropped.
`timescale 1ns/100ps
`default_nettype none

module sbr_req_buf
  import sbr_pkg::*;
(
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               reset_i,
  // Fill side
  input  wire logic               in_valid_i,
  output logic                    in_ready_o,
  input  wire sbr_pkg::sbr_req_t  in_data_i,
  // Drain side
  output logic                    out_valid_o,
  input  wire logic               out_ready_i,
  output sbr_pkg::sbr_req_t       out_data_o
);
  import sbr_pkg::*;

  sbr_req_t   mem_r [BUF_DEPTH];
  logic       wr_ptr_r;
  logic       rd_ptr_r;
  logic [1:0] cnt_r;
  logic       push;
  logic       pop;

  assign in_ready_o  = (cnt_r != BUF_FULL_CNT);
  assign out_valid_o = (cnt_r != BUF_RESET_CNT);
  assign out_data_o  = mem_r[rd_ptr_r];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop)
      begin
        rd_ptr_r <= ~rd_ptr_r;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cnt_r <= BUF_RESET_CNT;
    end
    else if (push && !pop)
    begin
      cnt_r <= cnt_r + 2'h1;
    end
    else if (pop && !push)
    begin
      cnt_r <= cnt_r - 2'h1;
    end
  end

endmodule

`default_nettype wire

/* sbr_track.sv */
// Purpose: Counts reads whose address was taken and whose data is still due.
// Assumes: Responses return in address order.
// Notes:   No timeout; a lost response leaves the count stuck.
`timescale 1ns/100ps
`default_nettype none

module sbr_track
  import sbr_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  // Events
  input  wire logic              taken_i,
  input  wire logic              done_i,
  // Status
  output logic [sbr_pkg::CNT_W-1:0] count_o,
  output logic                   full_o,
  output logic                   busy_o
);
  import sbr_pkg::*;

  logic [CNT_W-1:0] cnt_r;

  assign count_o = cnt_r;
  assign full_o  = (cnt_r == MAX_OUTSTANDING);
  assign busy_o  = (cnt_r != CNT_RESET);

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cnt_r <= CNT_RESET;
    end
    else if (taken_i && !done_i)
    begin
      cnt_r <= cnt_r + CNT_ONE;
    end
    else if (done_i && !taken_i)
    begin
      cnt_r <= cnt_r - CNT_ONE;
    end
  end

  a_cnt_bound: assert property (@(posedge clk_i) disable iff (reset_i) cnt_r <= MAX_OUTSTANDING)
    else $error("outstanding count above limit");

endmodule

`default_nettype wire

/* sbr_bus_master.sv */
// Purpose: System bus master for single reads with split read and write data.
// Assumes: Controller on the same clock; read data returns in address order.
// Notes:   Write path is not issued here; its data bus is held at zero.
`timescale 1ns/100ps
`default_nettype none

module sbr_bus_master
  import sbr_pkg::*;
(
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          reset_i,
  // Core request side
  input  wire logic                          req_valid_i,
  output logic                               req_ready_o,
  input  wire sbr_pkg::sbr_req_t             req_i,
  // Core response side
  output logic                               rsp_valid_o,
  output sbr_pkg::sbr_rsp_t                  rsp_o,
  output logic [sbr_pkg::CNT_W-1:0]          outstanding_o,
  // Bus address phase
  output logic [sbr_pkg::ADDR_HI:sbr_pkg::ADDR_LO] bus_doubleword_address_o,
  output logic [sbr_pkg::BE_W-1:0]           byte_lane_enables_o,
  output logic                               address_valid_o,
  output logic                               instruction_fetch_flag_o,
  output logic                               transfer_direction_flag_o,
  input  wire logic                          address_accept_i,
  // Bus data phase
  output logic [sbr_pkg::DATA_W-1:0]         write_bus_word_o,
  input  wire logic [sbr_pkg::DATA_W-1:0]    read_bus_word_i,
  input  wire logic                          read_word_valid_i,
  input  wire logic                          read_bus_error_i
);
  import sbr_pkg::*;

  sbr_state_t       state_r;
  sbr_state_t       state_nxt;
  sbr_req_t         addr_r;
  logic             fetch_r;
  sbr_req_t         buf_data;
  logic             buf_valid;
  logic             buf_ready;
  logic             pop;
  logic             taken;
  logic             rsp_take;
  logic             trk_full;
  logic             trk_busy;
  logic [CNT_W-1:0] trk_count;
  logic             rsp_valid_r;
  sbr_rsp_t         rsp_r;

  // Fetch qualifier only for uncached instruction fetch
  function automatic logic fetch_qual(input sbr_req_t r);
    fetch_qual = r.ifetch && r.uncached;
  endfunction

  sbr_req_buf u_buf (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (req_valid_i),
    .in_ready_o  (req_ready_o),
    .in_data_i   (req_i),
    .out_valid_o (buf_valid),
    .out_ready_i (buf_ready),
    .out_data_o  (buf_data)
  );

  sbr_track u_track (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .taken_i (taken),
    .done_i  (rsp_take),
    .count_o (trk_count),
    .full_o  (trk_full),
    .busy_o  (trk_busy)
  );

  // Address taken on the edge where accept is sampled with valid high
  assign taken = (state_r == SBR_OFFER) && address_accept_i;

  // Refill only outside the offer phase; full tracker blocks issue
  assign buf_ready = (state_r != SBR_OFFER) && !trk_full;
  assign pop       = buf_valid && buf_ready;

  // Tracker count is registered, so with none outstanding the accepting edge itself never samples
  assign rsp_take = trk_busy && read_word_valid_i;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      SBR_IDLE:
      begin
        if (pop)
        begin
          state_nxt = SBR_OFFER;
        end
      end
      SBR_OFFER:
      begin
        if (address_accept_i)
        begin
          state_nxt = SBR_HOLD;
        end
      end
      SBR_HOLD:
      begin
        if (pop)
        begin
          state_nxt = SBR_OFFER;
        end
        else
        begin
          state_nxt = SBR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state_r <= SBR_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Address lines only reload on a pop, so offer and hold keep them still
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      addr_r  <= '0;
      fetch_r <= 1'b0;
    end
    else if (pop)
    begin
      addr_r  <= buf_data;
      fetch_r <= fetch_qual(buf_data);
    end
  end

  assign bus_doubleword_address_o  = addr_r.addr;
  assign byte_lane_enables_o       = addr_r.be;
  assign instruction_fetch_flag_o  = fetch_r && (state_r == SBR_OFFER);
  assign address_valid_o           = (state_r == SBR_OFFER);
  assign transfer_direction_flag_o = DIR_READ;
  // Write data has its own bus; nothing is written by this block
  assign write_bus_word_o          = '0;

  // Response capture; no timeout while waiting
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rsp_valid_r <= 1'b0;
    end
    else
    begin
      rsp_valid_r <= rsp_take;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rsp_r <= '0;
    end
    else if (rsp_take)
    begin
      rsp_r.data <= read_bus_word_i;
      rsp_r.err  <= read_bus_error_i;
    end
  end

  assign rsp_valid_o   = rsp_valid_r;
  assign rsp_o         = rsp_r;
  assign outstanding_o = trk_count;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_offer_wait;
    address_valid_o && !address_accept_i;
  endsequence

  sequence s_offer_take;
    address_valid_o && address_accept_i;
  endsequence

  sequence s_pop_uncached_fetch;
    pop && buf_data.ifetch && buf_data.uncached;
  endsequence

  sequence s_pop_other;
    pop && !(buf_data.ifetch && buf_data.uncached);
  endsequence

  a_addr_wait_hold: assert property (s_offer_wait |=> address_valid_o
      && $stable(bus_doubleword_address_o) && $stable(byte_lane_enables_o))
    else $error("address changed before accept");

  a_addr_after_take: assert property (s_offer_take |=> !address_valid_o
      && $stable(bus_doubleword_address_o) && $stable(byte_lane_enables_o))
    else $error("address not held one clock after accept");

  a_addr_issue: assert property (pop |=> address_valid_o
      && bus_doubleword_address_o == $past(buf_data.addr)
      && byte_lane_enables_o == $past(buf_data.be))
    else $error("popped request not driven on the bus");

  a_fetch_set: assert property (s_pop_uncached_fetch |=> instruction_fetch_flag_o)
    else $error("uncached fetch not qualified");

  a_fetch_clear: assert property (s_pop_other |=> !instruction_fetch_flag_o)
    else $error("fetch qualifier raised for other read");

  a_dir_read: assert property (address_valid_o |-> transfer_direction_flag_o == DIR_READ)
    else $error("direction flag not read");

  a_write_idle: assert property (write_bus_word_o == '0)
    else $error("write bus driven by read path");

  a_limit_issue: assert property (trk_count == MAX_OUTSTANDING |=> !$rose(address_valid_o))
    else $error("address issued with sixteen outstanding");

  a_count_step: assert property ((s_offer_take and !rsp_take) |=> trk_count == $past(trk_count) + CNT_ONE)
    else $error("accepted read not counted");

  a_first_sample: assert property ((s_offer_take and !trk_busy) ##1 read_word_valid_i |=> rsp_valid_o)
    else $error("data not sampled one edge after accept");

  a_early_ignore: assert property (!trk_busy && read_word_valid_i |=> !rsp_valid_o)
    else $error("data sampled before accept edge");

  a_rsp_capture: assert property (trk_busy && read_word_valid_i |=> rsp_valid_o
      && rsp_o.data == $past(read_bus_word_i) && rsp_o.err == $past(read_bus_error_i))
    else $error("read word or error not captured");

  a_wait_no_timeout: assert property (trk_busy && !read_word_valid_i && !taken
      |=> trk_count == $past(trk_count) && !rsp_valid_o)
    else $error("pending read dropped without data");

  // Internal handshakes that the bus checks rely on;
  // a reload during an offer would move the address under the controller.
  sequence s_data_seen;
    trk_busy && read_word_valid_i;
  endsequence

  a_no_reload_offer: assert property (address_valid_o |-> !pop)
    else $error("request buffer popped during offer");

  a_full_no_pop: assert property (trk_full |-> !pop)
    else $error("request popped with tracker full");

  a_issue_room: assert property ($rose(address_valid_o) |-> $past(trk_count) != MAX_OUTSTANDING)
    else $error("offer started with no room");

  a_fetch_in_offer: assert property (instruction_fetch_flag_o |-> address_valid_o)
    else $error("fetch qualifier without address valid");

  a_count_drop: assert property ((s_data_seen and !taken) |=> trk_count == $past(trk_count) - CNT_ONE)
    else $error("returned word not retired");

  a_count_idle: assert property (!taken && !rsp_take |=> trk_count == $past(trk_count))
    else $error("outstanding count moved without event");

  a_rsp_source: assert property (rsp_valid_o |-> $past(trk_busy && read_word_valid_i))
    else $error("response without sampled read valid");

  a_rsp_keep: assert property (!rsp_take |=> $stable(rsp_o))
    else $error("response word changed without capture");

  a_err_source: assert property (rsp_valid_o && rsp_o.err |-> $past(read_bus_error_i && read_word_valid_i))
    else $error("bus error reported without its word");

endmodule

`default_nettype wire

/* sbr_ctl_model.sv */
// Purpose: Behavioural bus controller facing the single-read master.
// Assumes: Same clock as the master; responses strictly in address order.
// Notes:   Data lines toggle while no word is valid, so stale data never looks good.
`timescale 1ns/100ps
`default_nettype none

module sbr_ctl_model
  import sbr_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   reset_i,
  // Scenario controls
  input  wire logic                   stall_i,
  input  wire logic                   hold_i,
  input  wire logic [3:0]             gap_i,
  input  wire logic                   stray_i,
  // Bus
  input  wire logic [ADDR_HI:ADDR_LO] addr_i,
  input  wire logic                   avalid_i,
  output logic                        accept_o,
  output logic [DATA_W-1:0]           rdata_o,
  output logic                        rvalid_o,
  output logic                        rerr_o
);
  logic [ADDR_HI:ADDR_LO] pend_q[$];
  logic [3:0]             wait_r;

  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pend_q.delete();
      accept_o <= 1'b0;
      rvalid_o <= 1'b0;
      rerr_o   <= 1'b0;
      rdata_o  <= 64'h0f0f0f0f0f0f0f0f;
      wait_r   <= 4'h0;
    end
    else
    begin
      accept_o <= !stall_i;
      rvalid_o <= 1'b0;
      rerr_o   <= 1'b0;
      rdata_o  <= ~rdata_o;
      // Take first, so a zero gap answers on the first legal sampling edge
      if (avalid_i && accept_o)
        pend_q.push_back(addr_i);
      // Every taken address is answered once hold drops
      if (pend_q.size() > 0 && !hold_i)
      begin
        if (wait_r < gap_i)
          wait_r <= wait_r + 4'h1;
        else
        begin
          rvalid_o <= 1'b1;
          rdata_o  <= {28'h5a5a5a5, pend_q[0], 3'h0};
          rerr_o   <= pend_q[0][ADDR_HI];
          void'(pend_q.pop_front());
          wait_r   <= 4'h0;
        end
      end
      else if (stray_i && pend_q.size() == 0)
        rvalid_o <= 1'b1;
    end
  end
endmodule

`default_nettype wire

/* system_bus_single_read_test.sv */
// Purpose: Self-checking bench for the single-read bus master.
// Assumes: Controller model answers in order; inputs change on falling edges.
// Notes:   Top address bit asks the model for a bus error on that read.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end

module system_bus_single_read_test;
  import sbr_pkg::*;
  logic                   clk_i = 0;
  logic                   reset_i = 1;
  logic                   req_valid_i = 0;
  logic                   stall = 0;
  logic                   hold = 0;
  logic                   stray = 0;
  logic                   held = 0;
  logic [3:0]             gap = 4'h0;
  sbr_req_t               req_i = '0;
  sbr_req_t               e;
  sbr_rsp_t               rsp_o;
  logic                   req_ready_o, rsp_valid_o, avalid, ifl, dir, accept, rvalid, rerr;
  logic [CNT_W-1:0]       outst;
  logic [ADDR_HI:ADDR_LO] addr, held_a, a;
  logic [BE_W-1:0]        be;
  logic [DATA_W-1:0]      wword, rdata;
  int                     n_mismatch = 0;
  int                     n_tests = 0;
  sbr_req_t               exp_q[$];
  logic [ADDR_HI:ADDR_LO] rsp_q[$];

  initial forever #2.5 clk_i = ~clk_i;

  sbr_bus_master i_sbr_bus_master (.clk_i(clk_i), .reset_i(reset_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_i(req_i), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o),
    .outstanding_o(outst), .bus_doubleword_address_o(addr), .byte_lane_enables_o(be),
    .address_valid_o(avalid), .instruction_fetch_flag_o(ifl), .transfer_direction_flag_o(dir),
    .address_accept_i(accept), .write_bus_word_o(wword), .read_bus_word_i(rdata),
    .read_word_valid_i(rvalid), .read_bus_error_i(rerr));
  sbr_ctl_model i_sbr_ctl_model (.clk_i(clk_i), .reset_i(reset_i), .stall_i(stall), .hold_i(hold),
    .stray_i(stray), .gap_i(gap), .addr_i(addr), .avalid_i(avalid), .accept_o(accept), .rdata_o(rdata),
    .rvalid_o(rvalid), .rerr_o(rerr));

  always @(posedge clk_i)
  begin
    if (held)
      `CHK(addr, held_a)
    held <= 1'b0;
    if (!reset_i && avalid && accept && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      `CHK(addr, e.addr)
      `CHK(be, e.be)
      `CHK(ifl, e.ifetch & e.uncached)
      `CHK(dir, DIR_READ)
      `CHK(wword, 64'h0)
      `CHK(outst < MAX_OUTSTANDING, 1'b1)
      rsp_q.push_back(e.addr);
      held   <= 1'b1;
      held_a <= addr;
    end
    if (rsp_valid_o)
    begin
      a = rsp_q.size() > 0 ? rsp_q.pop_front() : '1;
      `CHK(rsp_o, {28'h5a5a5a5, a, 3'h0, a[ADDR_HI]})
    end
  end

  task automatic end_of_test();
    if (n_mismatch == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic timeout();
    n_mismatch++;
    end_of_test();
  endtask

  // Called at a falling edge; holds the request until the taking edge
  task automatic send(input sbr_req_t r);
    int k;
    req_valid_i = 1'b1;
    req_i       = r;
    for (k = 0; k < 200 && req_ready_o !== 1'b1; k++)
      @(negedge clk_i);
    if (k == 200)
      timeout();
    @(posedge clk_i);
    exp_q.push_back(r);
    @(negedge clk_i);
  endtask

  task automatic drain();
    int k;
    req_valid_i = 1'b0;
    for (k = 0; k < 500 && (outst !== 0 || exp_q.size() > 0 || rsp_q.size() > 0 || avalid !== 0); k++)
      @(negedge clk_i);
    if (k == 500)
      timeout();
    `CHK(outst, CNT_RESET)
  endtask

  task automatic t_reset();
    repeat (20) @(negedge clk_i);
    `CHK(avalid, 1'b0)
    `CHK(outst, CNT_RESET)
    `CHK(req_ready_o, 1'b1)
    `CHK(wword, 64'h0)
    reset_i = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask

  // Read valid with nothing outstanding must be ignored
  task automatic t_stray();
    stray = 1'b1;
    repeat (3) @(negedge clk_i);
    stray = 1'b0;
    repeat (3)
    begin
      `CHK(rsp_valid_o, 1'b0)
      `CHK(outst, CNT_RESET)
      @(negedge clk_i);
    end
  endtask

  // All fetch/cacheability combinations, back to back
  task automatic t_codes();
    for (int i = 0; i < 4; i++)
      send('{addr: 33'h100 + i, be: 8'h01 << i, ifetch: i[0], uncached: i[1]});
    drain();
  endtask

  task automatic t_stall();
    stall = 1'b1;
    gap   = 4'h3;
    send('{addr: 33'h0_0000_0abc, be: 8'hf0, ifetch: 1'b1, uncached: 1'b1});
    req_valid_i = 1'b0;
    repeat (3) @(negedge clk_i);
    repeat (4)
    begin
      `CHK(avalid, 1'b1)
      `CHK(outst, CNT_RESET)
      @(negedge clk_i);
    end
    stall = 1'b0;
    drain();
    gap = 4'h0;
  endtask

  // Overfill: tracker and buffer both refuse, then everything drains
  task automatic t_limit();
    int k;
    hold = 1'b1;
    for (int i = 0; i < 18; i++)
      send('{addr: {i[0], 24'h0, i[7:0]}, be: 8'hff, ifetch: 1'b0, uncached: 1'b0});
    req_valid_i = 1'b0;
    for (k = 0; k < 100 && outst !== MAX_OUTSTANDING; k++)
      @(negedge clk_i);
    repeat (4) @(negedge clk_i);
    `CHK(outst, MAX_OUTSTANDING)
    `CHK(avalid, 1'b0)
    `CHK(req_ready_o, 1'b0)
    hold = 1'b0;
    drain();
  endtask

  initial
  begin
    t_reset();
    t_stray();
    t_codes();
    t_stall();
    t_limit();
    end_of_test();
  end
endmodule

`default_nettype wire
